/* sfa_pkg.sv */
// Constants and types shared by the serial flash auxiliary command engine
// Function
// - Parameter table read 5Ah, 24-bit address, 8 dummies, data from clock 40 falling.
// - Security erase 44h is taken only with the write enable latch set.
// - Address 00h, bits 11-8 zero, bits 15-12 of 1, 2, 3 select a register.
// - Erase runs only if select rises right after the last address bit.
// - Self-timed erase holds busy high, status reads still answered, then busy clears.
// - A finished security erase clears the write enable latch.
// - A set lock bit makes erase and program of that register ignored.
// - Program 42h writes 1 to 256 bytes into erased bytes, latch required.
// - Security read 48h, address, 8 dummies, bytes MSB first until select rises.
// - Security read address increments and wraps from FFh to 00h.
// - Read parameter command C0h is rejected in standard serial mode.
// - Programmed dummy count applies only to 0Bh, EBh and 0Ch in quad mode.
// - Dummy code 00 to 11 means 2, 4, 6 or 8 dummy clocks.
// - Wrap code 00 to 11 means an 8, 16, 32 or 64 byte window.
// - Power-up or reset gives 8-byte wrap and 2 dummy clocks.
// - Burst wrap 77h sets wrap in serial mode, kept on entering quad mode.
// - Burst read 0Ch wraps to the start of the aligned wrap window.
// - Enter quad mode 38h is taken only with the quad enable bit set.
package sfa_pkg;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_PARAM_READ = 8'h5A;
    localparam logic [7:0] OP_SEC_ERASE  = 8'h44;
    localparam logic [7:0] OP_SEC_PROG   = 8'h42;
    localparam logic [7:0] OP_SEC_READ   = 8'h48;
    localparam logic [7:0] OP_SET_PARAMS = 8'hC0;
    localparam logic [7:0] OP_FAST_READ  = 8'h0B;
    localparam logic [7:0] OP_QUAD_READ  = 8'hEB;
    localparam logic [7:0] OP_WRAP_READ  = 8'h0C;
    localparam logic [7:0] OP_SET_WRAP   = 8'h77;
    localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
    localparam logic [7:0] OP_EXIT_QUAD  = 8'hFF;
    localparam logic [7:0] OP_READ_STAT  = 8'h05;
    localparam logic [7:0] OP_WR_ENABLE  = 8'h06;
    localparam logic [7:0] OP_WR_DISABLE = 8'h04;
    localparam logic [7:0] OP_RESET_EN   = 8'h66;
    localparam logic [7:0] OP_RESET      = 8'h99;

    // ------------------------------------------------------------
    // Frame layout in byte slots and field positions
    // ------------------------------------------------------------
    localparam logic [3:0] SLOT_ADDR_LAST = 4'h3;
    localparam logic [3:0] SLOT_DATA      = 4'h4;
    localparam logic [3:0] SLOT_WRAP_BYTE = 4'h4;
    localparam int         DUMMY_POS      = 4;
    localparam int         WRAP_POS       = 0;
    localparam int         BURST_WRAP_POS = 4;
    localparam logic [31:0] PARAM_SIG     = 32'h53464450;

    // ------------------------------------------------------------
    // Configuration and status carrier, reset value
    // ------------------------------------------------------------
    typedef struct packed {
        logic       quadCommandMode;
        logic       writeEnableLatch;
        logic [1:0] dummyCountCode;
        logic [1:0] wrapLenCode;
    } sfa_stat_type;

    localparam logic [1:0] DUMMY_RESET = 2'h0;
    localparam logic [1:0] WRAP_RESET  = 2'h0;
    localparam sfa_stat_type STAT_RESET = '{
        quadCommandMode:  1'b0,
        writeEnableLatch: 1'b0,
        dummyCountCode:   DUMMY_RESET,
        wrapLenCode:      WRAP_RESET
    };

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS         = 20;
    localparam int SECREG_ERASE_TIME_NS  = 20000;
    localparam logic [15:0] ERASE_CYCLES =
        16'((SECREG_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage : sfa_pkg

/* sfa_aux_cmd.sv */
// Auxiliary register command engine of the serial flash
`timescale 1ns/1ps
module sfa_aux_cmd
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  sclk,
    input  wire logic                  csN,
    input  wire logic [3:0]            ioIn,
    output logic      [3:0]            ioOut,
    output logic      [3:0]            ioOe,
    input  wire logic                  quadEnableBit,
    input  wire logic [2:0]            secregLockBits,
    output logic      [23:0]           arrayRdAddr,
    input  wire logic [7:0]            arrayRdData,
    output logic                       busy,
    output sfa_pkg::sfa_stat_type      statusOut
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [1:0]            rstSync;
    logic [1:0]            busySync;
    logic [1:0]            doneSync;
    logic                  doneSeen;
    logic [1:0]            quadEnSync;
    logic [2:0]            lockMeta;
    logic [2:0]            lockSync;
    logic [2:0]            bitPos;
    logic [3:0]            byteIdx;
    logic [7:0]            shiftIn;
    logic [7:0]            opcode;
    logic [23:0]           addr;
    logic [1:0]            secSel;
    logic                  secOk;
    logic                  reading;
    logic [7:0]            outByte;
    sfa_pkg::sfa_stat_type linkCfg;
    logic                  resetArmed;
    logic                  eraseArmed;
    logic [1:0]            eraseSel;
    logic [7:0]            secMem [3][256];
    logic [1:0]            csSync;
    logic                  csSeen;
    logic [1:0]            armSync;
    sfa_pkg::sfa_stat_type statMeta;
    logic [15:0]           eraseCnt;
    logic                  eraseDoneToggle;

    // ------------------------------------------------------------
    // Link reset and crossings into the link domain
    // ------------------------------------------------------------

    // Reset asserts at once, releases on link edges
    always_ff @(posedge sclk or posedge rst)
    begin
        if (rst)
            rstSync <= 2'h3;
        else
            rstSync <= {rstSync[0], 1'b0};
    end

    wire rstLink = rstSync[1];

    // Level and toggle synchronisers
    always_ff @(posedge sclk or posedge rstLink)
    begin
        if (rstLink)
        begin
            busySync   <= 2'h0;
            doneSync   <= 2'h0;
            doneSeen   <= 1'b0;
            quadEnSync <= 2'h0;
            lockMeta   <= 3'h0;
            lockSync   <= 3'h0;
        end
        else
        begin
            busySync   <= {busySync[0], busy};
            doneSync   <= {doneSync[0], eraseDoneToggle};
            doneSeen   <= doneSync[1];
            quadEnSync <= {quadEnSync[0], quadEnableBit};
            lockMeta   <= secregLockBits;
            lockSync   <= lockMeta;
        end
    end

    wire busyLink = busySync[1];
    wire doneEdge = doneSync[1] ^ doneSeen;

    // ------------------------------------------------------------
    // Beat decoding
    // ------------------------------------------------------------

    // Serial uses one line, quad mode all four
    wire       quad       = linkCfg.quadCommandMode;
    wire       serialIn   = ioIn[0];
    wire [7:0] inNext     = quad ? {shiftIn[3:0], ioIn} : {shiftIn[6:0], serialIn};
    wire [2:0] bitStep    = quad ? 3'h4 : 3'h1;
    wire [2:0] bitPosNext = bitPos + bitStep;
    wire       byteDone   = (bitPosNext == 3'h0);
    wire       opDone     = byteDone && (byteIdx == 4'h0);
    wire [7:0] opNow      = (byteIdx == 4'h0) ? inNext : opcode;

    // Security register selection from the address
    wire [23:0] addrNow  = {addr[15:0], inNext};
    wire        selOk    = (addrNow[23:16] == 8'h00) && (addrNow[11:8] == 4'h0) &&
                           (addrNow[15:12] != 4'h0) && (addrNow[15:12] <= 4'h3);
    wire [1:0]  selNow   = addrNow[13:12] - 2'h1;
    wire        lockedSel = lockSync[selNow];
    wire        writeOk  = linkCfg.writeEnableLatch && !busyLink && !quad &&
                           selOk && !lockedSel;
    wire        secOkNow = (opcode == sfa_pkg::OP_SEC_READ) ? (selOk && !quad) : writeOk;
    wire        lastAddr = byteDone && (byteIdx == sfa_pkg::SLOT_ADDR_LAST);

    // Erase armed on the last address bit only
    wire eraseHit = lastAddr && (opcode == sfa_pkg::OP_SEC_ERASE) && writeOk;

    // Program bytes stream while select stays low
    wire progByte = byteDone && (byteIdx >= sfa_pkg::SLOT_DATA) &&
                    (opcode == sfa_pkg::OP_SEC_PROG) && secOk;

    // ------------------------------------------------------------
    // Read decoding
    // ------------------------------------------------------------

    // Data slot: status at once, others fixed 8 dummies in serial, programmed in quad
    wire [3:0] dataStart = (opNow == sfa_pkg::OP_READ_STAT) ? 4'h1 :
                           quad ? (4'h5 + {2'h0, linkCfg.dummyCountCode}) :
                           4'h5;

    wire quadRead   = (opNow == sfa_pkg::OP_FAST_READ) || (opNow == sfa_pkg::OP_QUAD_READ) ||
                      (opNow == sfa_pkg::OP_WRAP_READ);
    wire serialRead = (opNow == sfa_pkg::OP_PARAM_READ) || (opNow == sfa_pkg::OP_FAST_READ) ||
                      ((opNow == sfa_pkg::OP_SEC_READ) && secOk);
    wire readOp     = (opNow == sfa_pkg::OP_READ_STAT) ||
                      (!busyLink && (quad ? quadRead : serialRead));
    wire loadFirst  = byteDone && readOp && ((byteIdx + 4'h1) == dataStart);
    wire loadNext   = byteDone && reading;
    wire addrLoad   = byteDone && (byteIdx != 4'h0) && (byteIdx <= sfa_pkg::SLOT_ADDR_LAST);

    // Byte sources
    wire [7:0] sigByte   = sfa_pkg::PARAM_SIG[{~addr[1:0], 3'h0} +: 8];
    wire [7:0] paramByte = (addr[7:2] == 6'h00) ? sigByte : 8'hFF;
    wire [7:0] secByte   = secMem[secSel][addr[7:0]];
    wire [7:0] statByte  = {6'h00, linkCfg.writeEnableLatch, busyLink};
    wire [7:0] rdByte    = (opNow == sfa_pkg::OP_READ_STAT)  ? statByte  :
                           (opNow == sfa_pkg::OP_PARAM_READ) ? paramByte :
                           (opNow == sfa_pkg::OP_SEC_READ)   ? secByte   :
                           arrayRdData;

    // Address step: table and register wrap at 256, burst wraps at window
    wire [23:0] wrapMask = (24'h000008 << linkCfg.wrapLenCode) - 24'h000001;
    wire [23:0] addrInc  = addr + 24'h000001;
    wire        inPage   = (opcode == sfa_pkg::OP_PARAM_READ) || (opcode == sfa_pkg::OP_SEC_READ) ||
                           (opcode == sfa_pkg::OP_SEC_PROG);
    wire [23:0] addrStep = (opcode == sfa_pkg::OP_WRAP_READ) ?
                           ((addr & ~wrapMask) | (addrInc & wrapMask)) :
                           inPage ? {addr[23:8], addrInc[7:0]} :
                           addrInc;

    assign arrayRdAddr = addr;

    // ------------------------------------------------------------
    // Frame state, cleared while select is high
    // ------------------------------------------------------------

    // Rising edge sampling of command, address and data
    always_ff @(posedge sclk or posedge csN)
    begin
        if (csN)
        begin
            bitPos  <= 3'h0;
            byteIdx <= 4'h0;
            shiftIn <= 8'h00;
            opcode  <= 8'h00;
            addr    <= 24'h000000;
            secSel  <= 2'h0;
            secOk   <= 1'b0;
            reading <= 1'b0;
            outByte <= 8'h00;
        end
        else
        begin
            bitPos  <= bitPosNext;
            shiftIn <= inNext;
            if (byteDone && (byteIdx != 4'hF))
                byteIdx <= byteIdx + 4'h1;
            if (opDone)
                opcode <= inNext;
            if (lastAddr)
            begin
                secSel <= selNow;
                secOk  <= secOkNow;
            end
            if (loadFirst || loadNext)
            begin
                outByte <= rdByte;
                reading <= 1'b1;
                addr    <= addrStep;
            end
            else if (addrLoad)
                addr <= addrNow;
            else if (progByte)
                addr <= addrStep;
        end
    end

    // Falling edge output, MSB first
    wire [3:0] quadNib   = (bitPos == 3'h0) ? outByte[7:4] : outByte[3:0];
    wire       serialBit = outByte[3'h7 - bitPos];

    always_ff @(negedge sclk or posedge csN)
    begin
        if (csN)
        begin
            ioOut <= 4'h0;
            ioOe  <= 4'h0;
        end
        else if (reading)
        begin
            ioOut <= quad ? quadNib : {2'h0, serialBit, 1'h0};
            ioOe  <= quad ? 4'hF : 4'h2;
        end
        else
        begin
            ioOut <= 4'h0;
            ioOe  <= 4'h0;
        end
    end

    // ------------------------------------------------------------
    // Persistent link state: latch, mode, read settings
    // ------------------------------------------------------------

    // Opcode effects taken when the opcode byte completes, C0h and 77h settings when their parameter byte does
    always_ff @(posedge sclk or posedge rstLink)
    begin
        if (rstLink)
        begin
            linkCfg    <= sfa_pkg::STAT_RESET;
            resetArmed <= 1'b0;
            eraseArmed <= 1'b0;
            eraseSel   <= 2'h0;
        end
        else
        begin
            eraseArmed <= eraseHit;
            if (eraseHit)
                eraseSel <= selNow;
            if (doneEdge)
                linkCfg.writeEnableLatch <= 1'b0;
            if (byteDone && (byteIdx == 4'h1) && quad &&
                (opcode == sfa_pkg::OP_SET_PARAMS))
            begin
                linkCfg.dummyCountCode <= inNext[sfa_pkg::DUMMY_POS +: 2];
                linkCfg.wrapLenCode    <= inNext[sfa_pkg::WRAP_POS +: 2];
            end
            if (byteDone && (byteIdx == sfa_pkg::SLOT_WRAP_BYTE) && !quad &&
                (opcode == sfa_pkg::OP_SET_WRAP))
                linkCfg.wrapLenCode <= inNext[sfa_pkg::BURST_WRAP_POS +: 2];
            if (opDone)
            begin
                resetArmed <= (inNext == sfa_pkg::OP_RESET_EN);
                if ((inNext == sfa_pkg::OP_WR_ENABLE) && !busyLink)
                    linkCfg.writeEnableLatch <= 1'b1;
                if ((inNext == sfa_pkg::OP_WR_DISABLE) && !busyLink)
                    linkCfg.writeEnableLatch <= 1'b0;
                if ((inNext == sfa_pkg::OP_ENTER_QUAD) && quadEnSync[1] && !busyLink)
                    linkCfg.quadCommandMode <= 1'b1;
                if ((inNext == sfa_pkg::OP_EXIT_QUAD) && quad && !busyLink)
                    linkCfg.quadCommandMode <= 1'b0;
                if ((inNext == sfa_pkg::OP_RESET) && resetArmed)
                    linkCfg <= sfa_pkg::STAT_RESET;
            end
        end
    end

    // Security register storage: erase to FFh, program clears bits
    always_ff @(posedge sclk)
    begin
        if (doneEdge)
        begin
            for (int i = 0; i < 256; i++)
                secMem[eraseSel][i] <= 8'hFF;
        end
        else if (progByte)
            secMem[secSel][addr[7:0]] <= secMem[secSel][addr[7:0]] & inNext;
    end

    // ------------------------------------------------------------
    // System domain: erase timer and status copy
    // ------------------------------------------------------------

    // Select and armed flag brought over; select rise starts the erase
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            csSync   <= 2'h3;
            csSeen   <= 1'b1;
            armSync  <= 2'h0;
            statMeta <= sfa_pkg::STAT_RESET;
            statusOut <= sfa_pkg::STAT_RESET;
        end
        else
        begin
            csSync   <= {csSync[0], csN};
            csSeen   <= csSync[1];
            armSync  <= {armSync[0], eraseArmed};
            if (csSync[1] && csSeen)
                statMeta <= linkCfg; // Word taken only once select has settled high
            statusOut <= statMeta;
        end
    end

    wire eraseStart = csSync[1] && !csSeen && armSync[1] && !busy;

    // Self-timed erase; done reported by toggle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            busy            <= 1'b0;
            eraseCnt        <= 16'h0000;
            eraseDoneToggle <= 1'b0;
        end
        else if (eraseStart)
        begin
            busy     <= 1'b1;
            eraseCnt <= sfa_pkg::ERASE_CYCLES - 16'h0001;
        end
        else if (busy && (eraseCnt == 16'h0000))
        begin
            busy            <= 1'b0;
            eraseDoneToggle <= ~eraseDoneToggle;
        end
        else if (busy)
            eraseCnt <= eraseCnt - 16'h0001;
    end

endmodule : sfa_aux_cmd

/* sfa_aux_cmd_asserts.sv */
// Port checker for the auxiliary command engine
`timescale 1ns/1ps
module sfa_aux_cmd_asserts
(
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  sclk,
    input wire logic                  csN,
    input wire logic [3:0]            ioIn,
    input wire logic [3:0]            ioOut,
    input wire logic [3:0]            ioOe,
    input wire logic                  quadEnableBit,
    input wire logic [2:0]            secregLockBits,
    input wire logic [23:0]           arrayRdAddr,
    input wire logic [7:0]            arrayRdData,
    input wire logic                  busy,
    input wire sfa_pkg::sfa_stat_type statusOut
);
    logic [15:0] busyCnt;

    // ------------------------------------------------
    // Helpers and sequences
    // ------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Length of the current busy stretch
    always_ff @(posedge clk)
    begin
        if (rst || !busy)
            busyCnt <= 16'h0000;
        else
            busyCnt <= busyCnt + 16'h0001;
    end

    sequence erase_start;
        $rose(busy);
    endsequence
    sequence erase_end;
        $fell(busy);
    endsequence
    sequence quad_entry;
        $rose(statusOut.quadCommandMode);
    endsequence

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    reset_defaults_a: assert property (disable iff (1'b0) rst ##1 rst |->
        statusOut == sfa_pkg::STAT_RESET && !busy) else $error("defaults missing in reset");
    erase_length_a: assert property (erase_end |->
        busyCnt == sfa_pkg::ERASE_CYCLES) else $error("erase length wrong");
    erase_gate_a: assert property (erase_start |->
        statusOut.writeEnableLatch && !statusOut.quadCommandMode) else $error("erase not gated");
    quad_gate_a: assert property (quad_entry |-> quadEnableBit)
        else $error("quad mode without enable");
    wrap_kept_a: assert property (quad_entry |-> $stable(statusOut.wrapLenCode))
        else $error("wrap changed on quad entry");
    serial_cfg_a: assert property (!statusOut.quadCommandMode &&
        $changed(statusOut.dummyCountCode) |-> statusOut.dummyCountCode == sfa_pkg::DUMMY_RESET)
        else $error("dummy code set in serial mode");
    idle_quiet_a: assert property (csN && $past(csN) |-> ioOe == 4'h0)
        else $error("driving while deselected");
    oe_shape_a: assert property (ioOe == 4'h0 ||
        (ioOe == 4'h2 && !statusOut.quadCommandMode) || (ioOe == 4'hF && statusOut.quadCommandMode))
        else $error("output enable pattern wrong");
endmodule : sfa_aux_cmd_asserts

bind sfa_aux_cmd sfa_aux_cmd_asserts sfa_aux_cmd_asserts_i (.clk(clk), .rst(rst), .sclk(sclk),
    .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .quadEnableBit(quadEnableBit),
    .secregLockBits(secregLockBits), .arrayRdAddr(arrayRdAddr), .arrayRdData(arrayRdData),
    .busy(busy), .statusOut(statusOut));

/* sfa_host_model.sv */
// Host serial bus controller model that drives frames into the flash
`timescale 1ns/1ps
module sfa_host_model
(
    output logic            sclk,
    output logic            csN,
    output logic [3:0]      hostOut,
    input  wire logic [3:0] ioWire
);
    // Idle bus: clock parked low, deselected, lines pulled up
    initial
    begin
        sclk = 1'b0;
        csN = 1'b1;
        hostOut = 4'hF;
    end

    // One link clock: drive after the fall, sample at the rise
    task tick(input logic [3:0] d, output logic [3:0] q);
        hostOut = d;
        #3 sclk = 1'b1;
        q = ioWire;
        #3 sclk = 1'b0;
    endtask : tick

    // One frame: bytes out, dummy clocks, bytes in, then deselect
    task frame(input logic quad, input logic [63:0] tx, input int nTx, input int nDum,
               input int nRx, output logic [31:0] rx);
        logic [3:0] q;
        logic [7:0] byteV;
        int         i;
        int         b;
        rx = 32'h0;
        csN = 1'b0;
        #4;
        for (i = 0; i < nTx; i++)
        begin
            byteV = tx[63 - 8 * i -: 8];
            if (quad)
            begin
                tick(byteV[7:4], q);
                tick(byteV[3:0], q);
            end
            else
                for (b = 7; b >= 0; b--)
                    tick({3'b111, byteV[b]}, q);
        end
        repeat (nDum) tick(~hostOut, q);
        for (i = 0; i < nRx; i++)
            repeat (quad ? 2 : 8)
            begin
                tick(~hostOut, q);
                rx = quad ? {rx[27:0], q} : {rx[30:0], q[1]};
            end
        #3 csN = 1'b1;
        hostOut = 4'hF;
        #30;
    endtask : frame
endmodule : sfa_host_model

/* tb_top.sv */
// Self-checking testbench for the auxiliary command engine
`timescale 1ns/1ps
module tb_top;
    localparam logic SER = 1'b0;
    localparam logic QD  = 1'b1;
    logic                  clk;
    logic                  rst;
    logic                  sclk;
    logic                  csN;
    logic [3:0]            hostOut;
    logic [3:0]            ioWire;
    logic [3:0]            ioOut;
    logic [3:0]            ioOe;
    logic                  quadEnableBit;
    logic [2:0]            secregLockBits;
    logic [23:0]           arrayRdAddr;
    logic [7:0]            arrayRdData;
    logic                  busy;
    sfa_pkg::sfa_stat_type statusOut;
    logic [31:0]           statB;
    logic [31:0]           rx;
    logic [23:0]           badAddr [0:3];
    int                    error_cnt;
    int                    num_checks;
    int                    n;
    int                    k;

    // Clock, shared data lines, main array stand-in
    always #10 clk = ~clk;
    assign ioWire = (ioOe & ioOut) | (~ioOe & hostOut);
    assign arrayRdData = arrayRdAddr[7:0] ^ 8'h3C;
    assign statB = {25'h0, statusOut, busy};

    sfa_aux_cmd sfa_aux_cmd_i (.clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .ioIn(ioWire),
        .ioOut(ioOut), .ioOe(ioOe), .quadEnableBit(quadEnableBit),
        .secregLockBits(secregLockBits), .arrayRdAddr(arrayRdAddr),
        .arrayRdData(arrayRdData), .busy(busy), .statusOut(statusOut));
    sfa_host_model sfa_host_model_i (.sclk(sclk), .csN(csN), .hostOut(hostOut), .ioWire(ioWire));

    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task end_sim;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    task cyc(input int c);
        repeat (c) @(posedge clk);
    endtask : cyc

    task cmd(input logic quad, input logic [63:0] tx, input int nTx, input int nDum,
             input int nRx);
        sfa_host_model_i.frame(quad, tx, nTx, nDum, nRx, rx);
        cyc(8);
    endtask : cmd

    task wait_busy(input logic lvl);
        int i;
        for (i = 0; i < 1100 && busy !== lvl; i++)
            @(posedge clk);
        if (busy !== lvl)
        begin
            chk("busy wait", {31'h0, lvl}, statB);
            end_sim();
        end
    endtask : wait_busy

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        quadEnableBit = 1'b0;
        secregLockBits = 3'h0;
        error_cnt = 0;
        num_checks = 0;
        badAddr = '{24'h001000, 24'h002000, 24'h004000, 24'h001100};
        cyc(16);
        chk("reset status", 32'h0, statB);
        rst <= 1'b0;
        cyc(4);
        cmd(SER, {8'h5A, 24'h000002, 32'h0}, 4, 8, 3);
        chk("table read", 32'h004450FF, rx);
        cmd(SER, {8'hC0, 8'h31, 48'h0}, 2, 0, 0);
        chk("serial set params", 32'h0, statB);
        cmd(SER, {8'h38, 56'h0}, 1, 0, 0);
        chk("quad without enable", 32'h0, statB);
        // Late deselect, locked, bad upper nibble, bad middle nibble
        for (k = 0; k < 4; k++)
        begin
            if (k == 1)
                secregLockBits <= 3'h2;
            cmd(SER, {8'h06, 56'h0}, 1, 0, 0);
            cmd(SER, {8'h44, badAddr[k], 32'h0}, 4, (k == 0) ? 1 : 0, 0);
            chk("refused erase", 32'h20, statB);
        end
        cmd(SER, {8'h04, 56'h0}, 1, 0, 0);
        cmd(SER, {8'h44, 24'h001000, 32'h0}, 4, 0, 0);
        chk("erase without latch", 32'h0, statB);
        cmd(SER, {8'h06, 56'h0}, 1, 0, 0);
        cmd(SER, {8'h44, 24'h001000, 32'h0}, 4, 0, 0);
        wait_busy(1'b1);
        cmd(SER, {8'h05, 56'h0}, 1, 0, 1);
        chk("status during erase", 32'h03, rx);
        wait_busy(1'b0);
        cmd(SER, {8'h05, 56'h0}, 1, 0, 1);
        chk("latch after erase", 32'h0, statB);
        cmd(SER, {8'h06, 56'h0}, 1, 0, 0);
        cmd(SER, {8'h42, 24'h0010FE, 16'hAA55, 16'h0}, 6, 0, 0);
        cmd(SER, {8'h48, 24'h0010FE, 32'h0}, 4, 8, 3);
        chk("secreg read wrap", 32'h00AA55FF, rx);
        secregLockBits <= 3'h3;
        cmd(SER, {8'h42, 24'h001000, 8'h00, 24'h0}, 5, 0, 0);
        cmd(SER, {8'h48, 24'h001000, 32'h0}, 4, 8, 1);
        chk("locked program", 32'h000000FF, rx);
        quadEnableBit <= 1'b1;
        cmd(SER, {8'h77, 24'h0, 8'h10, 24'h0}, 5, 0, 0);
        cmd(SER, {8'h38, 56'h0}, 1, 0, 0);
        chk("quad entry", 32'h62, statB);
        // Every dummy code against quad fast reads, 0Bh and EBh opcodes in turn
        for (k = 0; k < 4; k++)
        begin
            cmd(QD, {8'hC0, 2'h0, 2'(k), 4'h1, 48'h0}, 2, 0, 0);
            chk("dummy code", 32'h62 + 32'(8 * k), statB);
            cmd(QD, {k[0] ? 8'hEB : 8'h0B, 24'h000010, 32'h0}, 4, 2 + 2 * k, 2);
            chk("quad fast read", 32'h00002C2D, rx);
        end
        // Every wrap code, crossing the window end
        for (k = 0; k < 4; k++)
        begin
            n = (8 << k) - 2;
            cmd(QD, {8'hC0, 6'h0, 2'(k), 48'h0}, 2, 0, 0);
            cmd(QD, {8'h0C, 16'h0001, 8'(n), 32'h0}, 4, 2, 3);
            chk("wrap read", {8'h00, 8'(n) ^ 8'h3C, 8'(n + 1) ^ 8'h3C, 8'h3C}, rx);
        end
        cmd(QD, {8'hFF, 56'h0}, 1, 0, 0);
        chk("quad exit", 32'h26, statB);
        cmd(SER, {8'h38, 56'h0}, 1, 0, 0);
        cmd(QD, {8'h66, 56'h0}, 1, 0, 0);
        cmd(QD, {8'h99, 56'h0}, 1, 0, 0);
        chk("software reset", 32'h0, statB);
        end_sim();
    end

    // Run limit
    initial
    begin
        #1500000;
        chk("run time", 32'h0, 32'h1);
        end_sim();
    end
endmodule : tb_top
